// >>> rtl/sbf_formatter.sv
// Sample block output formatter with its output FIFO
`timescale 1ns/1ps
`include "sbf_map.svh"

module sbf_fifo #(
	parameter int W = 34,
	parameter int D = `SBF_FIFO_DEPTH
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_idx, rd_idx, next_wr_idx, next_rd_idx;
	logic [AW:0]   cnt, next_cnt;
	logic          do_wr, do_rd;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] i);
		bump = (i == AW'(D - 1)) ? '0 : i + 1'b1;
	endfunction : bump

	always_comb begin
		in_ready    = (cnt != (AW + 1)'(D));
		out_valid   = (cnt != '0);
		out_data    = mem[rd_idx];
		do_wr       = in_valid & in_ready;
		do_rd       = out_valid & out_ready;
		next_wr_idx = do_wr ? bump(wr_idx) : wr_idx;
		next_rd_idx = do_rd ? bump(rd_idx) : rd_idx;
		next_cnt    = cnt + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_idx <= '0;
			rd_idx <= '0;
			cnt    <= '0;
		end else begin
			wr_idx <= next_wr_idx;
			rd_idx <= next_rd_idx;
			cnt    <= next_cnt;
		end
	end

	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wr_idx] <= in_data;
		end
	end
endmodule : sbf_fifo

module sbf_formatter #(
	parameter int FIFO_DEPTH = `SBF_FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire sbf_pkg::sbf_cfg_s set_cfg,
	input  wire logic             set_all,
	input  wire logic             set_kind,
	input  wire logic             set_res,
	input  wire logic             set_mode,
	input  wire logic             set_blk,
	input  wire logic             set_append,
	input  wire logic             set_port,
	output sbf_pkg::sbf_cfg_s     cfg_now,
	output logic [22:0]           blk_len,
	output logic                  setup_err,
	output logic                  overflow,
	output logic                  busy,
	input  wire logic             arm,
	input  wire logic             trig,
	input  wire logic             smp_valid,
	input  wire logic [31:0]      smp_re,
	input  wire logic [31:0]      smp_im,
	input  wire logic             adc_ovl,
	input  wire logic             adc_err,
	output logic [31:0]           out_data,
	output logic                  out_last,
	output logic                  vme_valid,
	input  wire logic             vme_ready,
	output logic                  lbus_valid,
	input  wire logic             lbus_ready
);
	sbf_pkg::sbf_cfg_s  cfg, next_cfg, cur, next_cur;
	sbf_pkg::sbf_state_e state, next_state;
	logic [22:0] next_blk_len, cnt, next_cnt, cur_len, next_cur_len;
	logic        next_setup_err, next_overflow, req_bad, next_req_bad;
	logic        phase, next_phase, s_ovl, next_s_ovl, s_err, next_s_err;
	logic [31:0] im_hold, next_im_hold;
	logic [5:0]  lim;
	sbf_pkg::sbf_word_s push_word, pop_word;
	logic        push_valid, push_ready, pop_valid, pop_ready;
	logic        sample_done;
	logic [31:0] next_out_data;
	logic        next_out_last, next_vme_valid, next_lbus_valid, out_take;

	// Ceiling power of two, clamped to the format's range
	function automatic logic [23:0] fit_len(input logic [22:0] req, input logic kind, input logic res);
		logic [1:0]  bpp_log;
		logic [4:0]  max_e;
		logic [22:0] min_n, n, max_n;
		logic        err;
		bpp_log = 2'(kind) + 2'(res == `SBF_RES_32);
		max_e   = `SBF_MEM_LOG2 - 5'(bpp_log) - 5'd1;
		max_n   = 23'h000001 << max_e;
		unique case ({kind, res})
			2'b01:   min_n = `SBF_MIN_R16;
			2'b00:   min_n = `SBF_MIN_R32;
			2'b11:   min_n = `SBF_MIN_C16;
			default: min_n = `SBF_MIN_C32;
		endcase
		n = 23'h000001;
		for (int e = 0; e < 23; e++) begin
			if (n < req) begin
				n = n << 1;
			end
		end
		err = (req < min_n) || (req > max_n);
		if (n < min_n) begin
			n = (min_n > 23'h000002) ? 23'h000004 : min_n;
		end
		if (n > max_n) begin
			n = max_n;
		end
		fit_len = {err, n};
	endfunction : fit_len

	// Settings; length follows the stored request on every change
	always_comb begin
		next_cfg = cfg;
		// Clamping hides a bad request, so remember it until the next length request
		next_req_bad = req_bad;
		if (set_all || set_blk) next_req_bad = (set_cfg.req < `SBF_REQ_MIN) || (set_cfg.req > `SBF_REQ_MAX);
		if (set_all) begin
			next_cfg = set_cfg;
		end else begin
			if (set_kind)   next_cfg.kind   = set_cfg.kind;
			if (set_res)    next_cfg.res    = set_cfg.res;
			if (set_mode)   next_cfg.mode   = set_cfg.mode;
			if (set_append) next_cfg.append = set_cfg.append;
			if (set_port)   next_cfg.port   = set_cfg.port;
			if (set_blk)    next_cfg.req    = set_cfg.req;
		end
		if (next_cfg.req < `SBF_REQ_MIN) next_cfg.req = `SBF_REQ_MIN;
		if (next_cfg.req > `SBF_REQ_MAX) next_cfg.req = `SBF_REQ_MAX;
		{next_setup_err, next_blk_len} = fit_len(next_cfg.req, next_cfg.kind, next_cfg.res);
		next_setup_err = next_setup_err | next_req_bad;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg       <= '{kind: 1'b0, res: 1'b0, mode: 1'b0, append: 1'b0, port: 1'b0, req: `SBF_RST_REQ};
			blk_len   <= `SBF_RST_REQ;
			setup_err <= 1'b0;
			req_bad   <= 1'b0;
		end else begin
			cfg       <= next_cfg;
			req_bad   <= next_req_bad;
			blk_len   <= next_blk_len;
			setup_err <= next_setup_err;
		end
	end

	assign cfg_now = cfg;

	// Collector: samples to FIFO words
	always_comb begin
		next_state   = state;
		next_cur     = cur;
		next_cur_len = cur_len;
		next_cnt     = cnt;
		next_phase   = phase;
		next_im_hold = im_hold;
		next_s_ovl   = s_ovl;
		next_s_err   = s_err;
		next_overflow = overflow;
		push_valid   = 1'b0;
		push_word    = '{port: cur.port, last: 1'b0, data: 32'h00000000};
		sample_done  = 1'b0;
		unique case (state)
			sbf_pkg::SBF_IDLE: begin
				if (arm) next_state = sbf_pkg::SBF_ARMED;
			end
			sbf_pkg::SBF_ARMED: begin
				if (trig) begin
					next_state   = sbf_pkg::SBF_COLLECT;
					next_cur     = cfg;
					next_cur_len = blk_len;
					next_cnt     = '0;
					next_phase   = 1'b0;
					next_s_ovl   = 1'b0;
					next_s_err   = 1'b0;
				end
			end
			sbf_pkg::SBF_COLLECT: begin
				if (smp_valid) begin
					next_s_ovl = s_ovl | adc_ovl;
					next_s_err = s_err | adc_err;
				end
				if (phase) begin
					push_valid     = 1'b1;
					push_word.data = im_hold;
					if (push_ready) begin
						next_phase  = 1'b0;
						sample_done = 1'b1;
					end
					if (smp_valid) begin
						next_overflow = 1'b1;
						next_state    = sbf_pkg::SBF_HALT;
					end
				end else if (smp_valid) begin
					if (!push_ready) begin
						next_overflow = 1'b1;
						next_state    = sbf_pkg::SBF_HALT;
					end else begin
						push_valid = 1'b1;
						push_word.data = (cur.res == `SBF_RES_16) ? {16'h0000, smp_re[31:16]} : smp_re;
						next_im_hold   = (cur.res == `SBF_RES_16) ? {16'h0000, smp_im[31:16]} : smp_im;
						if (cur.kind == `SBF_KIND_CPLX) begin
							next_phase = 1'b1;
						end else begin
							sample_done = 1'b1;
						end
					end
				end
				if (sample_done) begin
					if (cnt == cur_len - 23'h000001) begin
						next_cnt = '0;
						push_word.last = !cur.append;
						if (cur.append) begin
							next_state = sbf_pkg::SBF_STAT;
						end else if (cur.mode == `SBF_MODE_BLOCK) begin
							next_state = sbf_pkg::SBF_IDLE;
						end else begin
							next_s_ovl = 1'b0;
							next_s_err = 1'b0;
						end
					end else begin
						next_cnt = cnt + 23'h000001;
					end
				end
			end
			sbf_pkg::SBF_STAT: begin
				push_valid = 1'b1;
				push_word.last = 1'b1;
				push_word.data[`SBF_STAT_OVL_BIT] = s_ovl;
				push_word.data[`SBF_STAT_ERR_BIT] = s_err;
				if (push_ready) begin
					next_s_ovl = 1'b0;
					next_s_err = 1'b0;
					// Continuous: straight back, no arm needed
					next_state = (cur.mode == `SBF_MODE_CONT) ? sbf_pkg::SBF_COLLECT : sbf_pkg::SBF_IDLE;
				end
				if (smp_valid && cur.mode == `SBF_MODE_CONT) begin
					next_overflow = 1'b1;
					next_state    = sbf_pkg::SBF_HALT;
				end
			end
			sbf_pkg::SBF_HALT: begin
				if (arm) next_state = sbf_pkg::SBF_ARMED;
			end
		endcase
		// Set wins over the clear by arm
		if (arm && state != sbf_pkg::SBF_COLLECT && state != sbf_pkg::SBF_STAT) begin
			next_overflow = 1'b0;
		end
		if (next_state == sbf_pkg::SBF_HALT && state != sbf_pkg::SBF_HALT) begin
			next_overflow = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state    <= sbf_pkg::SBF_IDLE;
			cur      <= '0;
			cur_len  <= 23'h000001;
			cnt      <= '0;
			phase    <= 1'b0;
			im_hold  <= 32'h00000000;
			s_ovl    <= 1'b0;
			s_err    <= 1'b0;
			overflow <= 1'b0;
			busy     <= 1'b0;
		end else begin
			state    <= next_state;
			cur      <= next_cur;
			cur_len  <= next_cur_len;
			cnt      <= next_cnt;
			phase    <= next_phase;
			im_hold  <= next_im_hold;
			s_ovl    <= next_s_ovl;
			s_err    <= next_s_err;
			overflow <= next_overflow;
			busy     <= (next_state == sbf_pkg::SBF_COLLECT) || (next_state == sbf_pkg::SBF_STAT);
		end
	end

	sbf_fifo #(
		.W ($bits(sbf_pkg::sbf_word_s)),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_word),
		.out_valid (pop_valid),
		.out_ready (pop_ready),
		.out_data  (pop_word)
	);

	// Output register keeps every port on a flop
	always_comb begin
		out_take        = (vme_valid & vme_ready) | (lbus_valid & lbus_ready);
		pop_ready       = !(vme_valid | lbus_valid) | out_take;
		next_out_data   = out_data;
		next_out_last   = out_last;
		next_vme_valid  = vme_valid & !out_take;
		next_lbus_valid = lbus_valid & !out_take;
		if (pop_ready && pop_valid) begin
			next_out_data   = pop_word.data;
			next_out_last   = pop_word.last;
			next_vme_valid  = (pop_word.port == `SBF_PORT_VME);
			next_lbus_valid = (pop_word.port == `SBF_PORT_LBUS);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_data   <= 32'h00000000;
			out_last   <= 1'b0;
			vme_valid  <= 1'b0;
			lbus_valid <= 1'b0;
		end else begin
			out_data   <= next_out_data;
			out_last   <= next_out_last;
			vme_valid  <= next_vme_valid;
			lbus_valid <= next_lbus_valid;
		end
	end
endmodule : sbf_formatter

// >>> rtl/sbf_map.svh
// Offsets-free constant map of the sample block output formatter
`ifndef SBF_MAP_SVH
`define SBF_MAP_SVH
// Memory size as a power of two in bytes (8 MB standard)
`define SBF_MEM_LOG2      5'd23
// Largest accepted request: memory size / 2
`define SBF_REQ_MAX       23'h400000
`define SBF_REQ_MIN       23'h000001
// Least block size in samples per format
`define SBF_MIN_R16       23'h000003
`define SBF_MIN_R32       23'h000002
`define SBF_MIN_C16       23'h000002
`define SBF_MIN_C32       23'h000001
// Setting encodings
`define SBF_KIND_REAL     1'b0
`define SBF_KIND_CPLX     1'b1
`define SBF_RES_32        1'b0
`define SBF_RES_16        1'b1
`define SBF_MODE_BLOCK    1'b0
`define SBF_MODE_CONT     1'b1
`define SBF_PORT_VME      1'b0
`define SBF_PORT_LBUS     1'b1
// Appended status byte fields, then the setup flag bit, which is never appended
`define SBF_STAT_OVL_BIT  0
`define SBF_STAT_ERR_BIT  1
`define SBF_FLAG_SETUP_BIT 6
// Reset value of the length request, and the output FIFO depth
`define SBF_RST_REQ       23'h000400
`define SBF_FIFO_DEPTH    16
`endif

// >>> rtl/sbf_pkg.sv
// Types shared by the sample block output formatter
package sbf_pkg;
	typedef struct packed {
		logic        kind;
		logic        res;
		logic        mode;
		logic        append;
		logic        port;
		logic [22:0] req;
	} sbf_cfg_s;

	typedef struct packed {
		logic        port;
		logic        last;
		logic [31:0] data;
	} sbf_word_s;

	typedef enum logic [2:0] {SBF_IDLE, SBF_ARMED, SBF_COLLECT, SBF_STAT, SBF_HALT} sbf_state_e;
endpackage : sbf_pkg

// >>> tb/sbf_formatter_monitor.sv
// Port checker of the sample block output formatter
`timescale 1ns/1ps
module sbf_formatter_monitor #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic              clk,
	input wire logic              rst,
	input wire sbf_pkg::sbf_cfg_s set_cfg,
	input wire logic              set_all,
	input wire logic              set_blk,
	input wire sbf_pkg::sbf_cfg_s cfg_now,
	input wire logic [22:0]       blk_len,
	input wire logic              setup_err,
	input wire logic              overflow,
	input wire logic              busy,
	input wire logic              arm,
	input wire logic [31:0]       out_data,
	input wire logic              out_last,
	input wire logic              vme_valid,
	input wire logic              vme_ready,
	input wire logic              lbus_valid,
	input wire logic              lbus_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_one_port: assert property (
		!(vme_valid && lbus_valid)) else $error("two ports valid");
	chk_len_pow2: assert property (
		blk_len != 23'h0 && (blk_len & (blk_len - 23'h1)) == 23'h0) else $error("length not power of two");
	// Widened sum so complex 32-bit shifts by two
	chk_len_max: assert property (
		blk_len <= (23'h400000 >> ({1'b0, cfg_now.kind} + {1'b0, ~cfg_now.res}))) else $error("length above max");
	chk_len_fit: assert property (
		!setup_err |-> blk_len >= cfg_now.req && {1'b0, blk_len} < {cfg_now.req, 1'b0})
		else $error("length not next power");
	chk_bad_req: assert property (
		(set_blk || set_all) && (set_cfg.req == 23'h0 || set_cfg.req > 23'h400000) |=> setup_err)
		else $error("no setup error");
	chk_cfg_all: assert property (
		set_all |=> cfg_now[27:23] == $past(set_cfg[27:23])) else $error("setup not applied");
	chk_vme_hold: assert property (
		vme_valid && !vme_ready |=> vme_valid && $stable(out_data) && $stable(out_last))
		else $error("vme word dropped");
	chk_lbus_hold: assert property (
		lbus_valid && !lbus_ready |=> lbus_valid && $stable(out_data) && $stable(out_last))
		else $error("lbus word dropped");
	chk_ovf_stick: assert property (
		overflow && !arm |=> overflow && !busy) else $error("overflow not held");
endmodule : sbf_formatter_monitor

bind sbf_formatter sbf_formatter_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (
	.clk(clk), .rst(rst), .set_cfg(set_cfg), .set_all(set_all), .set_blk(set_blk),
	.cfg_now(cfg_now), .blk_len(blk_len), .setup_err(setup_err), .overflow(overflow),
	.busy(busy), .arm(arm), .out_data(out_data), .out_last(out_last), .vme_valid(vme_valid),
	.vme_ready(vme_ready), .lbus_valid(lbus_valid), .lbus_ready(lbus_ready)
);

// >>> tb/sbf_sink.sv
// Output port reader model with selectable pace
`timescale 1ns/1ps
module sbf_sink (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        valid,
	input wire logic [31:0] data,
	input wire logic        last,
	input wire logic [1:0]  pace,
	output logic            ready
);
	logic [32:0] q[$];
	// Pace 0 drains each cycle, 1 every other, 2 stalls to force overflow
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ready <= 1'b0;
		end else begin
			if (valid && ready)
				q.push_back({last, data});
			ready <= (pace == 2'h0) || (pace == 2'h1 && !ready);
		end
	end
endmodule : sbf_sink

// >>> tb/tb.sv
// Self-checking bench of the sample block output formatter
`timescale 1ns/1ps
module tb;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	sbf_pkg::sbf_cfg_s set_cfg = '0;
	logic [6:0]        st = 7'h00;
	sbf_pkg::sbf_cfg_s cfg_now;
	logic [22:0]       blk_len;
	logic              setup_err, overflow, busy, out_last;
	logic              arm = 1'b0, trig = 1'b0, smp_valid = 1'b0;
	logic [31:0]       smp_re = 32'h0, smp_im = 32'h0, out_data;
	logic              adc_ovl = 1'b0, adc_err = 1'b0;
	logic              vme_valid, vme_ready, lbus_valid, lbus_ready;
	logic [1:0]        pace_v = 2'h0, pace_l = 2'h0;
	int                err_count = 0;
	int                tests_run = 0;
	always #50 clk = ~clk;
	sbf_formatter #(.FIFO_DEPTH(16)) u_dut (.clk(clk), .rst(rst), .set_cfg(set_cfg),
		.set_all(st[6]), .set_kind(st[0]), .set_res(st[1]), .set_mode(st[2]), .set_blk(st[3]),
		.set_append(st[4]), .set_port(st[5]), .cfg_now(cfg_now), .blk_len(blk_len),
		.setup_err(setup_err), .overflow(overflow), .busy(busy), .arm(arm), .trig(trig),
		.smp_valid(smp_valid), .smp_re(smp_re), .smp_im(smp_im), .adc_ovl(adc_ovl),
		.adc_err(adc_err), .out_data(out_data), .out_last(out_last), .vme_valid(vme_valid),
		.vme_ready(vme_ready), .lbus_valid(lbus_valid), .lbus_ready(lbus_ready));
	sbf_sink u_vme (.clk(clk), .rst(rst), .valid(vme_valid), .data(out_data), .last(out_last),
		.pace(pace_v), .ready(vme_ready));
	sbf_sink u_lbus (.clk(clk), .rst(rst), .valid(lbus_valid), .data(out_data), .last(out_last),
		.pace(pace_l), .ready(lbus_ready));
	task summarize;
		if (err_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task chk(input logic [32:0] e, input logic [32:0] g, input string m);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	function logic [32:0] lv();
		return {9'h0, setup_err, blk_len};
	endfunction : lv
	// Field order kind, res, mode, append, port
	task setc(input int b, input logic [22:0] r, input logic [4:0] f);
		@(posedge clk);
		set_cfg <= {f, r};
		st[b] <= 1'b1;
		@(posedge clk);
		st <= 7'h00;
		@(negedge clk);
	endtask : setc
	task go;
		@(posedge clk);
		arm <= 1'b1;
		@(posedge clk);
		arm <= 1'b0;
		trig <= 1'b1;
		@(posedge clk);
		trig <= 1'b0;
	endtask : go
	// Complex needs a free cycle after each sample for the imaginary word
	task send(input int n, input bit gap);
		for (int i = 0; i < n; i++) begin
			smp_valid <= 1'b1;
			smp_re <= {16'h1100 + i[15:0], 16'h0F0F};
			smp_im <= {16'h2200 + i[15:0], 16'h0F0F};
			adc_ovl <= (i == 1);
			adc_err <= (i == 0) && gap;
			@(posedge clk);
			if (gap) begin
				smp_valid <= 1'b0;
				@(posedge clk);
			end
		end
		smp_valid <= 1'b0;
	endtask : send
	task wait_q(input int n, input bit lb);
		int k;
		for (k = 0; k < 300; k++) begin
			if ((lb ? u_lbus.q.size() : u_vme.q.size()) >= n)
				break;
			@(posedge clk);
		end
		if (k == 300) begin
			chk(33'h1, 33'h0, "words missing");
			summarize();
		end
	endtask : wait_q
	task t_len;
		chk(33'h0000400, lv(), "reset length");
		setc(3, 23'h0003E8, 5'h00);
		chk(33'h0000400, lv(), "length 1000");
		setc(3, 23'h000000, 5'h00);
		chk(33'h0800002, lv(), "length 0");
		chk(33'h1, {10'h0, cfg_now.req}, "request 0");
		setc(3, 23'h2DC6C0, 5'h00);
		chk(33'h0A00000, lv(), "real32 max");
		setc(1, 23'h2DC6C0, 5'h08);
		chk(33'h0400000, lv(), "follow request");
		setc(3, 23'h7FFFFF, 5'h08);
		chk(33'h0C00000, lv(), "above memory");
		setc(3, 23'h000003, 5'h08);
		chk(33'h0000004, lv(), "real16 min");
	endtask : t_len
	task t_real;
		setc(6, 23'h000004, 5'h00);
		chk(33'h0, {28'h0, cfg_now[27:23]}, "setup fields");
		go();
		send(4, 1'b0);
		wait_q(4, 1'b0);
		for (int k = 0; k < 4; k++)
			chk({k == 3, 16'h1100 + k[15:0], 16'h0F0F}, u_vme.q[k], "real32 word");
		chk(33'h0, 33'(u_lbus.q.size()), "lbus used");
		u_vme.q.delete();
		@(posedge clk);
		trig <= 1'b1;
		@(posedge clk);
		trig <= 1'b0;
		send(2, 1'b0);
		repeat (20) @(posedge clk);
		chk(33'h0, 33'(u_vme.q.size()) + {32'h0, busy}, "trigger unarmed");
	endtask : t_real
	task t_cplx;
		pace_l <= 2'h1;
		setc(6, 23'h000002, 5'h1B);
		chk(33'h1B, {28'h0, cfg_now[27:23]}, "setup fields");
		go();
		send(2, 1'b1);
		wait_q(5, 1'b1);
		for (int k = 0; k < 2; k++) begin
			chk({17'h0, 16'h1100 + k[15:0]}, u_lbus.q[2 * k], "real half");
			chk({17'h0, 16'h2200 + k[15:0]}, u_lbus.q[2 * k + 1], "imag half");
		end
		chk(33'h100000003, u_lbus.q[4], "status word");
		chk(33'h0, 33'(u_vme.q.size()), "vme used");
	endtask : t_cplx
	task t_cont;
		setc(6, 23'h000002, 5'h04);
		chk(33'h0000002, lv(), "real32 length 2");
		go();
		send(4, 1'b0);
		wait_q(4, 1'b0);
		for (int k = 0; k < 4; k++)
			chk({k[0], 16'h1100 + k[15:0], 16'h0F0F}, u_vme.q[k], "gapless blocks");
		pace_v <= 2'h2;
		send(24, 1'b0);
		repeat (3) @(posedge clk);
		chk(33'h2, {31'h0, overflow, busy}, "overflow stop");
		pace_v <= 2'h0;
		go();
		chk(33'h0, {32'h0, overflow}, "overflow cleared");
	endtask : t_cont
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		t_len();
		t_real();
		t_cplx();
		t_cont();
		summarize();
	end
endmodule : tb
